// ### cfr_core_flags.sv
// core flag register with write guard, instruction cycle pacing and a
// small register port. assumes the execution unit runs on clk_sys and
// presents one decoded instruction while instr_valid is high.
`timescale 1ns/1ns
`default_nettype none

module cfr_core_flags
    import cfr_pkg::*;
#(
    parameter int unsigned ICYC_CLKS = CLK_PER_ICYC
)(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               srst,
    // instruction execution side
    input  wire logic               instr_valid,
    input  wire cfr_instr_s         instr,
    output logic                    instr_ready,
    output logic                    instr_retire,
    // reset-cause logic
    input  wire logic               cause_load,
    input  wire logic               cause_timeout,
    input  wire logic               cause_powerdown,
    // register port
    input  wire logic [FADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [DATA_W-1:0]       reg_rdata,
    // flag register view
    output logic [DATA_W-1:0]       flag_out
);

    localparam int unsigned CNT_W = (ICYC_CLKS > 1) ? $clog2(ICYC_CLKS) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ICYC_CLKS - 1);

    // divider needs at least one clock per instruction cycle
    if (ICYC_CLKS < 1) begin : g_bad_icyc
        $error("ICYC_CLKS must be at least 1");
    end

    typedef struct packed {
        logic [CNT_W-1:0]   cnt;
        logic               icyc_en;
        logic               branch_pend;
        logic               ready;
        logic               retire;
        logic [DATA_W-1:0]  flag;
        logic [INSTR_W-1:0] last_word;
        logic [DATA_W-1:0]  rdata;
    } cfr_state_s;

    cfr_state_s st_reg;
    cfr_state_s st_next;
    cfr_flags_s alu_flags;
    logic       take;
    logic       instr_hits_flag;
    logic [DATA_W-1:0] guard;

    // flag values for the instruction on offer
    cfr_flag_logic u_flag_logic (
        .instr (instr),
        .flags (alu_flags)
    );

    // next-state logic for pacing, flag register and register port
    always_comb begin
        st_next        = st_reg;
        st_next.retire = 1'b0;
        st_next.rdata  = '0;
        take           = 1'b0;
        guard          = DATA_WR_MASK;

        // instruction cycle enable from the clock divider
        st_next.icyc_en = (st_reg.cnt == CNT_LAST);
        st_next.cnt     = (st_reg.cnt == CNT_LAST) ? '0 : st_reg.cnt + 1'b1;

        if (st_reg.icyc_en) begin
            if (st_reg.branch_pend) begin
                st_next.branch_pend = 1'b0;
                st_next.ready       = 1'b1;
            end else if (instr_valid) begin
                take                = 1'b1;
                st_next.retire      = 1'b1;
                st_next.branch_pend = instr.branch;
                st_next.ready       = ~instr.branch;
            end
        end

        instr_hits_flag = take && instr.dest_wr && (instr.dest_addr == FLAG_ADDR);

        if (take) begin
            st_next.last_word = instr.word;
        end

        // guard alu bits on flag-affecting ops
        if (alu_flags.upd != 3'h0) begin
            guard = DATA_WR_MASK & ~ALU_FLAG_MASK;
        end

        if (instr_hits_flag) begin
            // clear zeroes page bits, sets z
            st_next.flag = (st_reg.flag & ~guard) | (instr.result & guard);
        end else if (reg_wr && reg_addr == FLAG_ADDR) begin
            // software write acts like a move
            st_next.flag = (st_reg.flag & ~DATA_WR_MASK) | (reg_wdata & DATA_WR_MASK);
        end

        // flag logic supplies z, nc, c
        if (take) begin
            if (alu_flags.upd[2]) st_next.flag[BIT_Z]  = alu_flags.z;
            if (alu_flags.upd[1]) st_next.flag[BIT_NC] = alu_flags.nc;
            if (alu_flags.upd[0]) st_next.flag[BIT_C]  = alu_flags.c;
        end

        // only the cause logic moves these
        if (cause_load) begin
            st_next.flag[BIT_TO] = cause_timeout;
            st_next.flag[BIT_PD] = cause_powerdown;
        end

        // read data stands the cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                FLAG_ADDR: st_next.rdata = st_reg.flag;
                STAT_ADDR: st_next.rdata = {6'h00, st_reg.branch_pend, st_reg.ready};
                default:   st_next.rdata = '0;
            endcase
        end
    end

    // state register
    // one byte holds alu and cause flags
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg       <= '0;
            st_reg.ready <= 1'b1;
            st_reg.flag  <= FLAG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    // page bits visible for paging
    assign instr_ready  = st_reg.ready;
    assign instr_retire = st_reg.retire;
    assign reg_rdata    = st_reg.rdata;
    assign flag_out     = st_reg.flag;

endmodule // cfr_core_flags

`default_nettype wire

// ### cfr_pkg.sv
// package for the core flag register block: addresses, field layout,
// reset values, operation classes and the structs that carry them.
// assumes a single core clock and a synchronous active-high reset.
package cfr_pkg;

    localparam int unsigned INSTR_W   = 12;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned FADDR_W   = 5;
    localparam int unsigned NIB_W     = 4;
    localparam int unsigned PROG_PAGE_WORDS = 512;

    // file and register-port addresses
    localparam logic [FADDR_W-1:0] FLAG_ADDR = 5'h03;
    localparam logic [FADDR_W-1:0] STAT_ADDR = 5'h1f;

    // flag register field positions
    localparam int unsigned BIT_SPARE = 7;
    localparam int unsigned BIT_PGHI  = 6;
    localparam int unsigned BIT_PGLO  = 5;
    localparam int unsigned BIT_TO    = 4;
    localparam int unsigned BIT_PD    = 3;
    localparam int unsigned BIT_Z     = 2;
    localparam int unsigned BIT_NC    = 1;
    localparam int unsigned BIT_C     = 0;

    // bits that instructions and software may write as plain data
    localparam logic [DATA_W-1:0] DATA_WR_MASK = 8'he7;
    // bits owned by the flag logic when an instruction affects them
    localparam logic [DATA_W-1:0] ALU_FLAG_MASK = 8'h07;
    // cause flags read as one after reset, all else zero
    localparam logic [DATA_W-1:0] FLAG_RST = 8'h18;

    // instruction cycle length in core clocks
    localparam int unsigned CLK_PER_ICYC = 4;

    // operation classes handed over by instruction decode
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_ADD    = 3'h1,
        OP_SUB    = 3'h2,
        OP_LOGIC  = 3'h3,
        OP_CLEAR  = 3'h4,
        OP_MOVE   = 3'h5,
        OP_BITCLR = 3'h6,
        OP_BITSET = 3'h7
    } cfr_op_e;

    // one decoded instruction from the execution unit
    typedef struct packed {
        logic [INSTR_W-1:0] word;
        cfr_op_e            op;
        logic               branch;
        logic               dest_wr;
        logic [FADDR_W-1:0] dest_addr;
        logic [DATA_W-1:0]  result;
        logic [DATA_W-1:0]  opa;
        logic [DATA_W-1:0]  opb;
    } cfr_instr_s;

    // flag logic answer: values and which of z, nc, c are touched
    typedef struct packed {
        logic       z;
        logic       nc;
        logic       c;
        logic [2:0] upd;
    } cfr_flags_s;

endpackage : cfr_pkg

// ### cfr_flag_logic.sv
// combinational flag logic: zero, nibble carry and carry per operation.
// assumes operands and result are stable for the taking clock edge.
`timescale 1ns/1ns
`default_nettype none

module cfr_flag_logic
    import cfr_pkg::*;
(
    // decoded instruction
    input  wire cfr_instr_s instr,
    // computed flags
    output cfr_flags_s      flags
);

    logic [DATA_W:0] sum;
    logic [NIB_W:0]  nsum;

    // subtraction keeps carry as "no borrow", so compare instead of add
    always_comb begin
        sum   = {1'b0, instr.opa} + {1'b0, instr.opb};
        nsum  = {1'b0, instr.opa[NIB_W-1:0]} + {1'b0, instr.opb[NIB_W-1:0]};
        flags = '0;
        case (instr.op)
            OP_ADD: begin
                flags.z   = (sum[DATA_W-1:0] == '0);
                flags.nc  = nsum[NIB_W];
                flags.c   = sum[DATA_W];
                flags.upd = 3'h7;
            end
            OP_SUB: begin
                flags.z   = (instr.opa == instr.opb);
                flags.nc  = (instr.opa[NIB_W-1:0] >= instr.opb[NIB_W-1:0]);
                flags.c   = (instr.opa >= instr.opb);
                flags.upd = 3'h7;
            end
            OP_LOGIC, OP_CLEAR: begin
                flags.z   = (instr.result == '0);
                flags.upd = 3'h4;   // zero only
            end
            default: begin
                flags = '0;         // move and bit ops leave flags alone
            end
        endcase
    end

endmodule // cfr_flag_logic

`default_nettype wire

// ### cfr_exec_model.sv
// execution unit model: offers one decoded instruction per go pulse.
// assumes the flag block pulses instr_retire for every taken one.
`timescale 1ns/1ns
`default_nettype none
module cfr_exec_model
    import cfr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // bench side
    input  wire logic       go,
    input  wire cfr_instr_s cmd,
    // block side
    input  wire logic       instr_retire,
    output cfr_instr_s      instr,
    output logic            instr_valid
);
    // bench picks ops
    // hold until retire, then invert so stale values never pass
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            instr_valid <= 1'b0;
            instr <= '0;
        end else if (go) begin
            instr_valid <= 1'b1;
            instr <= cmd;
        end else if (instr_retire) begin
            instr_valid <= 1'b0;
            instr <= ~instr;
        end
    end
endmodule // cfr_exec_model
`default_nettype wire

// ### cfr_core_flags_sva.sv
// port assertions for the core flag register.
// assumes one clock and the bench holding instructions until retire.
`timescale 1ns/1ns
`default_nettype none
module cfr_core_flags_sva
    import cfr_pkg::*;
#(
    parameter int unsigned ICYC_CLKS = CLK_PER_ICYC
)(
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               srst,
    // instruction side
    input wire logic               instr_valid,
    input wire cfr_instr_s         instr,
    input wire logic               instr_ready,
    input wire logic               instr_retire,
    input wire logic               cause_load,
    input wire logic               cause_timeout,
    input wire logic               cause_powerdown,
    // register port
    input wire logic [FADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0]  reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [DATA_W-1:0]  reg_rdata,
    input wire logic [DATA_W-1:0]  flag_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // retire of an instruction aimed at the flag register
    sequence s_flag_dst;
        instr_retire && $past(instr.dest_wr) && $past(instr.dest_addr) == FLAG_ADDR;
    endsequence
    a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero");
    a_rd_flag_view: assert property (reg_rd && reg_addr == FLAG_ADDR |=>
        reg_rdata == $past(flag_out)) else $error("flag read wrong");
    a_cause_guard: assert property (!cause_load |=> $stable(flag_out[4:3]))
        else $error("cause flags written");
    a_cause_load: assert property (cause_load |=> flag_out[4:3] ==
        {$past(cause_timeout), $past(cause_powerdown)}) else $error("cause not loaded");
    a_retire_gap: assert property (instr_retire |=> !instr_retire [*3])
        else $error("retire too close");
    a_clear_pattern: assert property (s_flag_dst ##0 $past(instr.op) == OP_CLEAR |->
        flag_out[7:5] == 3'b000 && flag_out[2]) else $error("clear pattern wrong");
    a_branch_stall: assert property (instr_retire && $past(instr.branch) |->
        !instr_ready) else $error("no branch dead cycle");
    a_port_write: assert property (reg_wr && reg_addr == FLAG_ADDR && !instr_valid |=>
        (flag_out & DATA_WR_MASK) == ($past(reg_wdata) & DATA_WR_MASK))
        else $error("port write lost");
endmodule // cfr_core_flags_sva
bind cfr_core_flags cfr_core_flags_sva #(.ICYC_CLKS(ICYC_CLKS)) u_sva (.clk_sys, .srst,
    .instr_valid, .instr, .instr_ready, .instr_retire, .cause_load, .cause_timeout,
    .cause_powerdown, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flag_out);
`default_nettype wire

// ### cfr_core_flags_tb.sv
// self-checking bench for the core flag register.
// assumes the execution model and checker compile alongside.
`timescale 1ns/1ns
`default_nettype none
module cfr_core_flags_tb;
    import cfr_pkg::*;
    logic clk_sys = 0, srst = 1, go = 0, instr_valid, instr_ready, instr_retire;
    logic cause_load = 0, cause_timeout = 0, cause_powerdown = 0;
    logic reg_wr = 0, reg_rd = 0, rd_d = 0;
    logic [FADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0]  reg_wdata = '0, reg_rdata, flag_out, fl;
    logic [31:0]        seed = 32'hf74a_64e5, r;
    cfr_instr_s         cmd = '0, instr, c;
    logic [7:0]         q[$];
    int                 n_errors = 0, cmp_count = 0, i, k;
    always #2 clk_sys = ~clk_sys;
    cfr_core_flags dut (.clk_sys, .srst, .instr_valid, .instr, .instr_ready,
        .instr_retire, .cause_load, .cause_timeout, .cause_powerdown, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flag_out);
    cfr_exec_model u_exec (.clk_sys, .srst, .go, .cmd, .instr_retire, .instr, .instr_valid);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (e !== g) begin
            n_errors++;
            $display("Error %s exp %h got %h", nm, e, g);
        end
    endtask
    // monitor: old values are read at the edge, so outputs are settled
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        if (rd_d) chk("rdata", q.pop_front(), reg_rdata);
        if (instr_retire) chk("flag", q.pop_front(), flag_out);
    end
    // strobe tasks leave a gap edge so no signal is set twice at once
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    // flag register after one instruction aimed at it
    function automatic logic [7:0] nxt(input cfr_instr_s x, input logic [7:0] o);
        logic [8:0] s;
        logic [7:0] e;
        s = {1'b0, x.opa} + {1'b0, x.opb};
        e = (o & ~DATA_WR_MASK) | (x.result & DATA_WR_MASK);
        case (x.op)
            OP_ADD: e[2:0] = {x.result == 0, x.opa[3:0] + x.opb[3:0] > 15, s[8]};
            OP_SUB: e[2:0] = {x.opa == x.opb, x.opa[3:0] >= x.opb[3:0], x.opa >= x.opb};
            OP_LOGIC, OP_CLEAR: e[2:0] = {x.result == 0, o[1:0]};
            default: e = e;
        endcase
        return e;
    endfunction
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(FLAG_ADDR, FLAG_RST);
        rd(5'h05, 8'h00);
        // idle core: ready set, no branch pending
        rd(STAT_ADDR, 8'h01);
        cause_load <= 1'b1;
        cause_powerdown <= 1'b1;
        @(posedge clk_sys) cause_load <= 1'b0;
        wr(FLAG_ADDR, 8'hff);
        wr(5'h05, 8'h00);
        fl = 8'hef;
        rd(FLAG_ADDR, fl);
        // every op class but OP_NONE, random operands, some branches
        for (i = 0; i < 21; i++) begin
            r = rnd();
            c = '0;
            c.op = cfr_op_e'(3'(i % 7 + 1));
            c.opa = r[7:0];
            c.opb = r[15:8];
            c.word = r[27:16];
            c.branch = r[31];
            c.dest_wr = 1'b1;
            c.dest_addr = FLAG_ADDR;
            c.result = c.op == OP_ADD ? c.opa + c.opb : c.op == OP_SUB ? c.opa - c.opb :
                c.op == OP_LOGIC ? c.opa & c.opb : c.op == OP_CLEAR ? 8'h00 : r[23:16];
            fl = nxt(c, fl);
            q.push_back(fl);
            cmd <= c;
            go <= 1'b1;
            @(posedge clk_sys) go <= 1'b0;
            for (k = 0; k < 40 && !instr_retire; k++) @(posedge clk_sys);
            if (k == 40) begin
                n_errors++;
                break;
            end
            @(posedge clk_sys);
            // read lands before the next instruction cycle, inside the dead cycle
            if (c.branch) rd(STAT_ADDR, 8'h02);
        end
        rd(FLAG_ADDR, fl);
        // let the monitor take the last read before the verdict
        repeat (2) @(posedge clk_sys);
        close_out();
    end
endmodule // cfr_core_flags_tb
`default_nettype wire
